// file: bench/light_sensor_config_control_test.sv
// Self-checking testbench of the sensor configuration and conversion sequencing.
module light_sensor_config_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sysClk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000, regRdData, got;
	logic regRdValid, afeOverflow, limitHighHit = 1'b0, limitLowHit = 1'b0;
	logic [11:0] afeMantissa;
	logic [3:0] afeRange, overloadLimit = 4'h0;
	logic afeActive, afeRestart;
	int errorCnt = 0, checked = 0, restarts;
	int cycleNo = 0, startNo = 0;
	// Short counts keep the run small; expectations below follow these values.
	lsc_sensor_config #(.CONV_SHORT_CYC(20), .CONV_LONG_CYC(160)) dut (.sys_clk(sysClk),
		.rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
		.afeMantissa(afeMantissa), .afeOverflow(afeOverflow), .limitHighHit(limitHighHit),
		.limitLowHit(limitLowHit), .afeRange(afeRange), .afeActive(afeActive),
		.afeRestart(afeRestart));
	lsc_afe_model afe (.afeRange(afeRange), .afeActive(afeActive), .overloadLimit(overloadLimit),
		.afeMantissa(afeMantissa), .afeOverflow(afeOverflow));
	// Clock at 25 MHz.
	initial begin
		forever #20 sysClk = ~sysClk;
	end
	// Free-running cycle count, so a whole pass can be timed from its write edge.
	always @(posedge sysClk) begin
		cycleNo <= cycleNo + 1;
	end
	// Inputs move 1 ns after the edge so the design never races the bench.
	task automatic tick();
		@(posedge sysClk);
		#1;
	endtask
	task automatic closeOut();
		$display("Counts: %0d compares, %0d mismatches", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp16(input logic [15:0] act, input logic [15:0] exp);
		checked++;
		if (act !== exp) begin
			errorCnt++;
			$display("unexpected value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic cmp1(input logic act, input logic exp);
		checked++;
		if (act !== exp) begin
			errorCnt++;
			$display("unexpected flag at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		tick();
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		tick();
		regWrEn = 1'b0;
	endtask
	// A read answers one cycle after the strobe; a missing answer ends the run.
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		tick();
		regAddr = a;
		regRdEn = 1'b1;
		tick();
		regRdEn = 1'b0;
		for (int i = 0; i < 4 && regRdValid !== 1'b1; i++) begin
			tick();
		end
		if (regRdValid !== 1'b1) begin
			errorCnt++;
			closeOut();
		end
		cmp16(regRdData, exp);
	endtask
	// Bounded wait for the end of a pass; a hang counts as a mismatch.
	task automatic waitIdle();
		for (int i = 0; i < 2000 && afeActive !== 1'b0; i++) begin
			tick();
		end
		if (afeActive !== 1'b0) begin
			errorCnt++;
			closeOut();
		end
	endtask
	// Main sequence; range codes stay within 0h..Ch throughout.
	initial begin
		repeat (4) tick();
		rst = 1'b0;
		rd(8'h01, 16'hC810);
		rd(8'h00, 16'h0000);
		rd(8'h05, 16'h0000);
		$display("test reset_values done");
		// Manual range 3, short time, single shot: two low bits are lost.
		wr(8'h01, 16'h3210);
		startNo = cycleNo;
		cmp1(afeActive, 1'b1);
		cmp16({12'h000, afeRange}, 16'h0003);
		rd(8'h01, 16'h3210);
		waitIdle();
		cmp16(16'(cycleNo - startNo), 16'h0014);
		rd(8'h01, 16'h3090);
		rd(8'h01, 16'h3010);
		rd(8'h00, 16'h3ABC);
		$display("test single_manual done");
		// Automatic ranging climbs past the overloaded ranges 0..3.
		overloadLimit = 4'h4;
		wr(8'h01, 16'hCA10);
		startNo = cycleNo;
		waitIdle();
		cmp16(16'(cycleNo - startNo), 16'h00A4);
		rd(8'h00, 16'h4ABF);
		rd(8'h01, 16'hC890);
		$display("test auto_range done");
		// Continuous mode, rewritten mid-pass with the other continuous code.
		overloadLimit = 4'h0;
		wr(8'h01, 16'h7410);
		repeat (15) tick();
		wr(8'h01, 16'h7610);
		cmp1(afeRestart, 1'b1);
		repeat (8) tick();
		rd(8'h00, 16'h4ABF);
		restarts = 0;
		for (int i = 0; i < 40; i++) begin
			tick();
			restarts += int'(afeRestart === 1'b1);
		end
		cmp16(16'(restarts), 16'h0002);
		limitHighHit = 1'b1;
		limitLowHit = 1'b1;
		tick();
		limitHighHit = 1'b0;
		limitLowHit = 1'b0;
		wr(8'h01, 16'h7010);
		cmp1(afeActive, 1'b0);
		rd(8'h01, 16'h70F0);
		rd(8'h01, 16'h7010);
		rd(8'h00, 16'h7ABF);
		$display("test continuous_abort done");
		// Short single shots at range 0, then at range 5 with the exponent masked.
		wr(8'h01, 16'h0210);
		waitIdle();
		rd(8'h00, 16'h0AB8);
		wr(8'h01, 16'h5214);
		waitIdle();
		rd(8'h00, 16'h0ABE);
		$display("test short_ranges done");
		closeOut();
	end
endmodule

// file: bench/lsc_afe_model.sv
// Behavioural front end that answers the conversion link of the sensor block.
module lsc_afe_model (
	input wire logic [3:0] afeRange,
	input wire logic afeActive,
	input wire logic [3:0] overloadLimit,
	output logic [11:0] afeMantissa,
	output logic afeOverflow
);
	timeunit 1ns;
	timeprecision 1ps;
	// Light overloads every range below overloadLimit; the inverse pattern shows when idle.
	assign afeOverflow = afeActive && (afeRange < overloadLimit);
	assign afeMantissa = afeActive ? 12'hABF : 12'h540;
endmodule

// file: verilog/lsc_pkg.sv
// Package with offsets, field layouts, reset values and timing of the sensor configuration block.
package lsc_pkg;
	// Register addresses.
	localparam logic [7:0] ADDR_RESULT = 8'h00;
	localparam logic [7:0] ADDR_SENSOR_CONFIGURATION = 8'h01;
	// Configuration field positions.
	localparam int RANGE_LSB = 12;
	localparam int CONV_TIME_BIT = 11;
	localparam int MODE_LSB = 9;
	localparam int OVERFLOW_FLAG_BIT = 8;
	localparam int CONV_READY_BIT = 7;
	localparam int ABOVE_BIT = 6;
	localparam int BELOW_BIT = 5;
	localparam int LATCH_BIT = 4;
	localparam int POL_BIT = 3;
	localparam int EXPMASK_BIT = 2;
	localparam int FAULT_LSB = 0;
	// Values after reset.
	localparam logic [15:0] CONFIG_RESET = 16'hC810;
	localparam logic [3:0] RANGE_RESET = 4'hC;
	localparam logic CONV_TIME_RESET = 1'b1;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic LATCH_RESET = 1'b1;
	localparam logic POLARITY_RESET = 1'b0;
	localparam logic EXPMASK_RESET = 1'b0;
	localparam logic [1:0] FAULT_RESET = 2'h0;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	// Range and mode codes.
	localparam logic [3:0] RANGE_AUTO = 4'hC;
	localparam logic [3:0] RANGE_MAX = 4'hB;
	localparam logic [3:0] RANGE_MIN = 4'h0;
	localparam logic [3:0] RANGE_ONE_BIT_LOSS = 4'h5;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	// Timing.
	localparam int CLK_HZ = 25_000_000;
	localparam int CONV_SHORT_MS = 100;
	localparam int CONV_LONG_MS = 800;
	localparam int CONV_SHORT_CYCLES = (CLK_HZ / 1000) * CONV_SHORT_MS;
	localparam int CONV_LONG_CYCLES = (CLK_HZ / 1000) * CONV_LONG_MS;
	localparam int CNT_W = 25;
	typedef enum logic {LSC_IDLE, LSC_CONVERT} lsc_state_t;
endpackage

// file: verilog/lsc_sensor_config.sv
// Configuration register, conversion sequencing and result capture of the light sensor.

module lsc_sensor_config #(
	parameter int CONV_SHORT_CYC = lsc_pkg::CONV_SHORT_CYCLES,
	parameter int CONV_LONG_CYC = lsc_pkg::CONV_LONG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	input wire logic regRdEn,
	output logic [15:0] regRdData,
	output logic regRdValid,
	input wire logic [11:0] afeMantissa,
	input wire logic afeOverflow,
	input wire logic limitHighHit,
	input wire logic limitLowHit,
	output logic [3:0] afeRange,
	output logic afeActive,
	output logic afeRestart
);
	logic [3:0] rangeSelect_q;
	logic convTimeSel_q;
	logic [1:0] mode_q;
	logic latch_q;
	logic polarity_q;
	logic expMask_q;
	logic [1:0] faultCount_q;
	logic overflowFlag_q;
	logic convReadyFlag_q;
	logic aboveLimitFlag_q;
	logic belowLimitFlag_q;
	logic [15:0] result_q;
	logic overloadSeen_q;
	logic [lsc_pkg::CNT_W-1:0] convCnt_q;
	lsc_pkg::lsc_state_t state_q;
	logic cfgWrite;
	logic cfgRead;
	logic [3:0] newRange;
	logic [1:0] newMode;
	logic autoMode;
	logic convLast;
	logic autoStep;
	logic convEnd;
	logic [15:0] cfgValue;
	logic [3:0] resultExp;
	logic [11:0] resMask;

	// Decode of register accesses; the written range and mode steer a restart.
	assign cfgWrite = regWrEn && (regAddr == lsc_pkg::ADDR_SENSOR_CONFIGURATION);
	assign cfgRead = regRdEn && (regAddr == lsc_pkg::ADDR_SENSOR_CONFIGURATION);
	assign newRange = regWrData[lsc_pkg::RANGE_LSB +: 4];
	assign newMode = regWrData[lsc_pkg::MODE_LSB +: 2];
	assign autoMode = (rangeSelect_q == lsc_pkg::RANGE_AUTO);

	// Conversion length follows the time select bit; both lengths are parameters for simulation.
	assign convLast = convTimeSel_q ?
		(convCnt_q == lsc_pkg::CNT_W'(CONV_LONG_CYC - 1)) :
		(convCnt_q == lsc_pkg::CNT_W'(CONV_SHORT_CYC - 1));

	// An overflow below the top range in auto mode aborts and climbs, even on the last cycle.
	assign autoStep = (state_q == lsc_pkg::LSC_CONVERT) && autoMode && afeOverflow &&
		(afeRange < lsc_pkg::RANGE_MAX) && !cfgWrite;
	assign convEnd = (state_q == lsc_pkg::LSC_CONVERT) && convLast && !autoStep && !cfgWrite;

	// Exponent mask only applies with a manual range, so auto results always carry their range.
	assign resultExp = (expMask_q && !autoMode) ? lsc_pkg::RANGE_MIN : afeRange;

	// Short conversions at low ranges lose low bits; step weight stays, bits read as zero.
	always_comb begin
		resMask = 12'hFFF;
		if (!convTimeSel_q) begin
			if (afeRange == lsc_pkg::RANGE_MIN) begin
				resMask = 12'hFF8;
			end else if (afeRange < lsc_pkg::RANGE_ONE_BIT_LOSS) begin
				resMask = 12'hFFC;
			end else if (afeRange == lsc_pkg::RANGE_ONE_BIT_LOSS) begin
				resMask = 12'hFFE;
			end
		end
	end

	// Ranges 1 to 4 lose two bits on short conversions; the mask must reach the result.
	a_short_low_bits: assert property (@(posedge sys_clk) disable iff (rst)
		convEnd && !convTimeSel_q && afeRange < lsc_pkg::RANGE_ONE_BIT_LOSS |=> result_q[1:0] == 2'h0)
		else $error("Short conversion kept two bits below resolution.");

	// Readback image of the configuration register.
	assign cfgValue = {rangeSelect_q, convTimeSel_q, mode_q, overflowFlag_q, convReadyFlag_q,
		aboveLimitFlag_q, belowLimitFlag_q, latch_q, polarity_q, expMask_q, faultCount_q};

	// Host-writable configuration fields.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rangeSelect_q <= lsc_pkg::RANGE_RESET;
			convTimeSel_q <= lsc_pkg::CONV_TIME_RESET;
			latch_q <= lsc_pkg::LATCH_RESET;
			polarity_q <= lsc_pkg::POLARITY_RESET;
			expMask_q <= lsc_pkg::EXPMASK_RESET;
			faultCount_q <= lsc_pkg::FAULT_RESET;
		end else if (cfgWrite) begin
			rangeSelect_q <= newRange;
			convTimeSel_q <= regWrData[lsc_pkg::CONV_TIME_BIT];
			latch_q <= regWrData[lsc_pkg::LATCH_BIT];
			polarity_q <= regWrData[lsc_pkg::POL_BIT];
			expMask_q <= regWrData[lsc_pkg::EXPMASK_BIT];
			faultCount_q <= regWrData[lsc_pkg::FAULT_LSB +: 2];
		end
	end

	// Mode field; a write in the same cycle as a single-shot end wins over the self-clear.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_q <= lsc_pkg::MODE_RESET;
		end else if (cfgWrite) begin
			mode_q <= newMode;
		end else if (convEnd && mode_q == lsc_pkg::MODE_SINGLE) begin
			mode_q <= lsc_pkg::MODE_SHUTDOWN;
		end
	end

	// Conversion sequencer: start, abort, auto-range climb and continuous repeat.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= lsc_pkg::LSC_IDLE;
			afeActive <= 1'b0;
			afeRestart <= 1'b0;
			convCnt_q <= '0;
			afeRange <= lsc_pkg::RANGE_MIN;
		end else if (cfgWrite) begin
			convCnt_q <= '0;
			if (newMode != lsc_pkg::MODE_SHUTDOWN) begin
				state_q <= lsc_pkg::LSC_CONVERT;
				afeActive <= 1'b1;
				afeRestart <= 1'b1;
				afeRange <= (newRange == lsc_pkg::RANGE_AUTO) ? lsc_pkg::RANGE_MIN : newRange;
			end else begin
				state_q <= lsc_pkg::LSC_IDLE;
				afeActive <= 1'b0;
				afeRestart <= 1'b0;
			end
		end else begin
			afeRestart <= 1'b0;
			unique case (state_q)
				lsc_pkg::LSC_IDLE: begin
					afeActive <= 1'b0;
				end
				lsc_pkg::LSC_CONVERT: begin
					if (autoStep) begin
						afeRange <= afeRange + 4'h1;
						convCnt_q <= '0;
						afeRestart <= 1'b1;
					end else if (convEnd) begin
						convCnt_q <= '0;
						if (mode_q[1]) begin
							afeRestart <= 1'b1;
							if (autoMode) begin
								afeRange <= lsc_pkg::RANGE_MIN;
							end
						end else begin
							state_q <= lsc_pkg::LSC_IDLE;
							afeActive <= 1'b0;
						end
					end else begin
						convCnt_q <= convCnt_q + lsc_pkg::CNT_W'(1);
					end
				end
			endcase
		end
	end

	// Overflow seen during the current pass; cleared on each start so every result is fresh.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overloadSeen_q <= 1'b0;
		end else if (cfgWrite || autoStep || convEnd) begin
			overloadSeen_q <= 1'b0;
		end else if (state_q == lsc_pkg::LSC_CONVERT && afeOverflow) begin
			overloadSeen_q <= 1'b1;
		end
	end

	// Result and overflow capture at the end of a conversion.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			result_q <= lsc_pkg::RESULT_RESET;
			overflowFlag_q <= 1'b0;
		end else if (convEnd) begin
			result_q <= {resultExp, afeMantissa & resMask};
			overflowFlag_q <= overloadSeen_q || afeOverflow;
		end
	end

	// Ready flag: the set wins over a clearing access; shutdown writes leave it alone.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			convReadyFlag_q <= 1'b0;
		end else if (convEnd) begin
			convReadyFlag_q <= 1'b1;
		end else if (cfgRead || (cfgWrite && newMode != lsc_pkg::MODE_SHUTDOWN)) begin
			convReadyFlag_q <= 1'b0;
		end
	end

	// A read, or a write that is not a shutdown, must clear the flag unless a pass ends.
	a_ready_clear: assert property (@(posedge sys_clk) disable iff (rst)
		!convEnd && (cfgRead || (cfgWrite && newMode != lsc_pkg::MODE_SHUTDOWN))
		|=> !convReadyFlag_q)
		else $error("Ready flag survived a clearing access.");

	// Limit flags come from the comparison logic; mode changes never touch them.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aboveLimitFlag_q <= 1'b0;
			belowLimitFlag_q <= 1'b0;
		end else begin
			aboveLimitFlag_q <= limitHighHit || (aboveLimitFlag_q && !cfgRead);
			belowLimitFlag_q <= limitLowHit || (belowLimitFlag_q && !cfgRead);
		end
	end

	// Read port: one cycle latency, unmapped addresses read as zero.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			regRdData <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) begin
				if (regAddr == lsc_pkg::ADDR_SENSOR_CONFIGURATION) begin
					regRdData <= cfgValue;
				end else if (regAddr == lsc_pkg::ADDR_RESULT) begin
					regRdData <= result_q;
				end else begin
					regRdData <= 16'h0000;
				end
			end
		end
	end

	// Sequencing checks; they watch only what this block drives.
	a_abort_on_write: assert property (@(posedge sys_clk) disable iff (rst)
		cfgWrite && newMode == lsc_pkg::MODE_SHUTDOWN |=> state_q == lsc_pkg::LSC_IDLE && !afeActive)
		else $error("Conversion kept running after a shutdown write.");

	a_restart_on_write: assert property (@(posedge sys_clk) disable iff (rst)
		cfgWrite && newMode != lsc_pkg::MODE_SHUTDOWN |=> afeActive && afeRestart && convCnt_q == '0)
		else $error("Active-mode write did not restart the conversion.");

	a_reset_value: assert property (@(posedge sys_clk)
		rst |=> cfgValue == lsc_pkg::CONFIG_RESET)
		else $error("Configuration does not read its reset value.");

	a_auto_exponent: assert property (@(posedge sys_clk) disable iff (rst)
		convEnd && autoMode |=> result_q[15:12] == $past(afeRange))
		else $error("Auto result exponent differs from range used.");

	a_single_holds: assert property (@(posedge sys_clk) disable iff (rst)
		mode_q == lsc_pkg::MODE_SINGLE && !convEnd && !cfgWrite |=> mode_q == lsc_pkg::MODE_SINGLE)
		else $error("Single-shot mode field changed before the end.");

	a_single_clears: assert property (@(posedge sys_clk) disable iff (rst)
		convEnd && mode_q == lsc_pkg::MODE_SINGLE |=> mode_q == lsc_pkg::MODE_SHUTDOWN && !afeActive)
		else $error("Single-shot end did not enter shutdown.");

	a_ready_kept: assert property (@(posedge sys_clk) disable iff (rst)
		cfgWrite && newMode == lsc_pkg::MODE_SHUTDOWN && !cfgRead |=> $stable(convReadyFlag_q))
		else $error("Shutdown write altered the ready flag.");

	a_ready_set: assert property (@(posedge sys_clk) disable iff (rst)
		convEnd |=> convReadyFlag_q)
		else $error("Ready flag not set at the end of a conversion.");

	a_auto_climb: assert property (@(posedge sys_clk) disable iff (rst)
		autoStep |=> afeRange == $past(afeRange) + 4'h1 && convCnt_q == '0 && afeRestart)
		else $error("Auto overflow did not climb one range and restart.");

	a_cont_restart: assert property (@(posedge sys_clk) disable iff (rst)
		convEnd && mode_q[1] |=> state_q == lsc_pkg::LSC_CONVERT && convCnt_q == '0 && afeRestart)
		else $error("Continuous mode did not restart after completion.");

	a_short_resolution: assert property (@(posedge sys_clk) disable iff (rst)
		convEnd && !convTimeSel_q && afeRange == lsc_pkg::RANGE_MIN |=> result_q[2:0] == 3'h0)
		else $error("Short conversion kept bits below resolution.");
endmodule
